// *** dv/dist_post_properties.sv ***
`timescale 1ns/100ps
`include "dist_post_cfg.svh"
module dist_post_properties #(
    parameter int          WIDTH = 32,
    parameter logic [31:0] LO    = `RANGE_LO,
    parameter logic [31:0] HI    = `RANGE_HI
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             ce,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic             rawValid,
    input wire logic             rawEcho,
    input wire logic             laserOn,
    input wire logic [1:0]       rxGainSel,
    input wire logic             distValid,
    input wire logic             noSignal,
    input wire logic [WIDTH-1:0] limLo,
    input wire logic [WIDTH-1:0] limHi,
    input wire logic             irq
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_reset_defaults: assert property (
        $fell(rst) |-> laserOn && noSignal && !distValid && !irq && limLo == LO && limHi == HI)
        else $error("state after reset wrong");
    chk_laser_off_nosig: assert property (
        rawValid && ce && !laserOn ##1 (!laserOn && ce) |-> ##1 noSignal)
        else $error("no-signal missing, laser off");
    chk_no_echo_nosig: assert property (
        rawValid && ce && !rawEcho ##1 ce |-> ##1 noSignal)
        else $error("no-signal missing, no echo");
    chk_gain_legal: assert property (
        rxGainSel != 2'h3) else $error("gain select out of range");
    chk_out_has_cause: assert property (
        distValid && $past(ce) && $past(ce, 2) |-> $past(rawValid, 2))
        else $error("value without sample");
    chk_laser_off_quiet: assert property (
        !laserOn [*4] |-> !distValid) else $error("value while laser off");
    chk_gain_by_write: assert property (
        $changed(rxGainSel) && !$past(rst) |->
        $past(psel && penable && pwrite && paddr == `OFS_CTRL) ||
        $past(psel && penable && pwrite && paddr == `OFS_CTRL, 2)) else $error("gain moved alone");
    chk_laser_by_write: assert property (
        $changed(laserOn) && !$past(rst) |->
        $past(psel && penable && pwrite && paddr == `OFS_CTRL) ||
        $past(psel && penable && pwrite && paddr == `OFS_CTRL, 2)) else $error("laser moved alone");
endmodule

bind dist_post dist_post_properties #(.WIDTH(WIDTH), .LO(LO), .HI(HI)) props (
    .clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .rawValid, .rawEcho, .laserOn,
    .rxGainSel, .distValid, .noSignal, .limLo, .limHi, .irq);

// *** dv/dist_post_tb.sv ***
`timescale 1ns/100ps
`include "dist_post_cfg.svh"
module dist_post_tb;
    localparam logic [31:0] HI = `RANGE_HI;
    logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, er;
    logic        rawValid, rawEcho, laserOn, distValid, noSignal, irq, frz;
    logic [1:0]  rxGainSel;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rawDist, distOut, limLo, limHi, rd;
    int          n_mismatch;
    int          comparisons;

    dist_post dut (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rawValid, .rawEcho, .rawDist, .laserOn, .rxGainSel, .distValid,
        .distOut, .noSignal, .limLo, .limHi, .irq);
    front_end_model fe (.clk, .laserOn, .rawValid, .rawEcho, .rawDist);

    always #5 clk = ~clk;

    // ----
    // tasks
    // ----
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, rd);
    endtask

    task automatic meas(input logic [31:0] d, input logic v, input logic [31:0] e);
        logic        got;
        logic [31:0] seen;
        got = 1'b0;
        seen = 32'h0;
        fe.fire(d);
        repeat (4) begin
            @(posedge clk);
            #1;
            if (distValid === 1'b1) begin
                got = 1'b1;
                seen = distOut;
            end
        end
        chk("distValid", {31'h0, v}, {31'h0, got});
        if (v) chk("distOut", e, seen);
        else chk("noSignal", 32'h1, {31'h0, noSignal});
    endtask

    // ----
    // sequence
    // ----
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc(`OFS_CTRL, 32'h0000_0103);
        rdc(`OFS_OFFSET, 32'h0);
        rdc(`OFS_WINMIN, 32'h0);
        rdc(`OFS_WINMAX, HI);
        apb(1'b0, 8'h28, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        $display("test defaults done");
        wr(`OFS_CTRL, 32'h0000_0100);
        meas(32'h3E8, 1'b1, 32'h3E8);
        wr(`OFS_OFFSET, 32'h1F4);
        meas(32'h7D0, 1'b1, 32'h9C4);
        chk("limLo", 32'h1F4, limLo);
        chk("limHi", HI + 32'h1F4, limHi);
        wr(`OFS_IRQMASK, 32'h0);
        wr(`OFS_TARGET, 32'h1B58);
        wr(`OFS_APPLY, 32'h1);
        rdc(`OFS_OFFSET, 32'h1388);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`OFS_IRQMASK, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`OFS_IRQSTAT, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        meas(32'hBB8, 1'b1, 32'h1F40);
        $display("test offset done");
        wr(`OFS_OFFSET, 32'h0);
        wr(`OFS_WINMIN, 32'h3E8);
        wr(`OFS_WINMAX, 32'h1388);
        meas(32'h1F4, 1'b0, 32'h0);
        meas(32'hBB8, 1'b1, 32'hBB8);
        meas(32'h1770, 1'b0, 32'h0);
        $display("test window done");
        wr(`OFS_CTRL, 32'h0000_0101);
        meas(32'h3E8, 1'b1, 32'h3E8);
        meas(32'hBB8, 1'b1, 32'h7D0);
        $display("test filter done");
        for (int s = 0; s < 3; s++) begin
            wr(`OFS_CTRL, 32'h0000_0100 | (32'(s) << 4));
            repeat (2) @(posedge clk);
            chk("rxGainSel", 32'(s), {30'h0, rxGainSel});
            meas(32'h7D0, 1'b1, 32'h7D0);
        end
        $display("test sensitivity done");
        @(posedge clk);
        ce <= 1'b0;
        fe.fire(32'h7D0);
        frz = 1'b0;
        repeat (4) begin
            @(posedge clk);
            #1;
            frz = frz | distValid;
        end
        chk("frozen distValid", 32'h0, {31'h0, frz});
        chk("frozen noSignal", 32'h0, {31'h0, noSignal});
        @(posedge clk);
        ce <= 1'b1;
        $display("test freeze done");
        wr(`OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk("laserOn", 32'h0, {31'h0, laserOn});
        meas(32'h7D0, 1'b0, 32'h0);
        $display("test laser done");
        conclude();
    end
endmodule

// *** dv/front_end_model.sv ***
`timescale 1ns/100ps
module front_end_model (
    input  wire logic        clk,
    input  wire logic        laserOn,
    output logic             rawValid,
    output logic             rawEcho,
    output logic      [31:0] rawDist
);
    initial begin
        rawValid = 1'b0;
        rawEcho = 1'b0;
        rawDist = 32'h0;
    end

    // one raw sample, then the distance bus shows garbage
    task automatic fire(input logic [31:0] d);
        @(posedge clk);
        rawValid <= 1'b1;
        rawDist <= d;
        rawEcho <= laserOn;
        @(posedge clk);
        rawValid <= 1'b0;
        rawEcho <= 1'b0;
        rawDist <= ~d;
    endtask
endmodule

// *** rtl/dist_post.sv ***
`timescale 1ns/100ps
`include "dist_post_cfg.svh"

module dist_post #(
    parameter int          WIDTH = 32,
    parameter logic [31:0] LO    = `RANGE_LO,
    parameter logic [31:0] HI    = `RANGE_HI
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // apb
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // front end
    input  wire logic             rawValid,
    input  wire logic             rawEcho,
    input  wire logic [WIDTH-1:0] rawDist,
    output logic                  laserOn,
    output logic      [1:0]       rxGainSel,
    // output stages
    output logic                  distValid,
    output logic      [WIDTH-1:0] distOut,
    output logic                  noSignal,
    output logic      [WIDTH-1:0] limLo,
    output logic      [WIDTH-1:0] limHi,
    output logic                  irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0]         filt_q;
    dist_post_pkg::sens_t sens_q;
    logic               laser_q;
    logic [31:0]        offset_q;
    logic [31:0]        target_q;
    logic [31:0]        winMin_q;
    logic [31:0]        winMax_q;
    logic [2:0]         irqStat_q;
    logic [2:0]         irqMask_q;
    logic [WIDTH-1:0]   lastRaw_q;
    logic               lastOk_q;

    logic               wrEn;
    logic               rdEn;
    logic               applyCmd;
    logic               mapped;
    logic [2:0]         irqEvt;

    assign wrEn     = psel && penable && pwrite && ce;
    assign rdEn     = psel && penable && !pwrite && ce;
    assign applyCmd = wrEn && (paddr == `OFS_APPLY) && pwdata[0];

    always_comb begin
        if (paddr == `OFS_CTRL) begin
            mapped = 1'b1;
        end else if (paddr == `OFS_OFFSET || paddr == `OFS_TARGET) begin
            mapped = 1'b1;
        end else if (paddr == `OFS_WINMIN || paddr == `OFS_WINMAX) begin
            mapped = 1'b1;
        end else if (paddr == `OFS_APPLY || paddr == `OFS_STATUS) begin
            mapped = 1'b1;
        end else if (paddr == `OFS_IRQSTAT || paddr == `OFS_IRQMASK) begin
            mapped = 1'b1;
        end else if (paddr == `OFS_RESULT) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            filt_q  <= `FILT_RST;
            sens_q  <= dist_post_pkg::SENS_STANDARD;
            laser_q <= `LASER_RST;
        end else if (wrEn && paddr == `OFS_CTRL) begin
            filt_q  <= (pwdata[`CTRL_FILT_MSB:`CTRL_FILT_LSB] > `FILT_MAX) ?
                       `FILT_MAX : pwdata[`CTRL_FILT_MSB:`CTRL_FILT_LSB];
            // reserved code falls back to standard
            sens_q  <= (pwdata[`CTRL_SENS_MSB:`CTRL_SENS_LSB] == 2'h3) ?
                       dist_post_pkg::SENS_STANDARD :
                       dist_post_pkg::sens_t'(pwdata[`CTRL_SENS_MSB:`CTRL_SENS_LSB]);
            laser_q <= pwdata[`CTRL_LASER_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            offset_q <= `OFFSET_RST;
            target_q <= `TARGET_RST;
        end else if (ce) begin
            if (applyCmd && lastOk_q) begin
                offset_q <= target_q - 32'(lastRaw_q);
            end else if (wrEn && paddr == `OFS_OFFSET) begin
                offset_q <= pwdata;
            end
            if (wrEn && paddr == `OFS_TARGET) begin
                target_q <= pwdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            winMin_q <= LO;
            winMax_q <= HI;
        end else if (wrEn && paddr == `OFS_WINMIN) begin
            winMin_q <= pwdata;
        end else if (wrEn && paddr == `OFS_WINMAX) begin
            winMax_q <= pwdata;
        end
    end

    // ------------------------------------------------------------
    // measurement path
    // ------------------------------------------------------------
    logic             inWin;
    logic             gatedValid;
    logic             avgValid;
    logic [WIDTH-1:0] avgData;
    logic             flushAvg;

    assign inWin = rawEcho && (32'(rawDist) >= winMin_q) && (32'(rawDist) <= winMax_q);
    assign gatedValid = rawValid && laser_q && inWin;
    assign flushAvg   = (wrEn && paddr == `OFS_CTRL) || (rawValid && !gatedValid);

    always_ff @(posedge clk) begin
        if (rst) begin
            lastRaw_q <= '0;
            lastOk_q  <= 1'b0;
        end else if (ce && rawValid) begin
            lastRaw_q <= rawDist;
            lastOk_q  <= gatedValid;
        end else if (ce && !laser_q) begin
            lastOk_q  <= 1'b0;
        end
    end

    running_avg #(
        .WIDTH (WIDTH),
        .DEPTH (512)
    ) u_avg (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .flush    (flushAvg),
        .inValid  (gatedValid && filt_q != 4'h0),
        .inData   (rawDist),
        .shift    (filt_q),
        .outValid (avgValid),
        .outData  (avgData)
    );

    logic             bypValid_q;
    logic [WIDTH-1:0] bypData_q;
    logic             nosigEvt_q;

    // zero bypasses, aligned to average latency
    always_ff @(posedge clk) begin
        if (rst) begin
            bypValid_q <= 1'b0;
            bypData_q  <= '0;
            nosigEvt_q <= 1'b0;
        end else if (ce) begin
            bypValid_q <= gatedValid && filt_q == 4'h0;
            bypData_q  <= rawDist;
            nosigEvt_q <= (rawValid && !gatedValid) || !laser_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            distValid <= 1'b0;
            distOut   <= '0;
            noSignal  <= 1'b1;
        end else if (ce) begin
            distValid <= avgValid || bypValid_q;
            if (avgValid) begin
                distOut  <= avgData + WIDTH'(offset_q);
                noSignal <= 1'b0;
            end else if (bypValid_q) begin
                distOut  <= bypData_q + WIDTH'(offset_q);
                noSignal <= 1'b0;
            end else if (nosigEvt_q) begin
                noSignal <= 1'b1;
            end
        end
    end

    // limits shifted by offset; gain only, rate untouched; emitter
    always_ff @(posedge clk) begin
        if (rst) begin
            limLo     <= WIDTH'(LO);
            limHi     <= WIDTH'(HI);
            rxGainSel <= 2'h0;
            laserOn   <= `LASER_RST;
        end else if (ce) begin
            limLo     <= WIDTH'(winMin_q + offset_q);
            limHi     <= WIDTH'(winMax_q + offset_q);
            rxGainSel <= sens_q;
            laserOn   <= laser_q;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign irqEvt = {applyCmd && lastOk_q, nosigEvt_q, avgValid || bypValid_q};

    always_ff @(posedge clk) begin
        if (rst) begin
            irqStat_q <= '0;
            irqMask_q <= '0;
            irq       <= 1'b0;
        end else if (ce) begin
            if (wrEn && paddr == `OFS_IRQSTAT) begin
                irqStat_q <= (irqStat_q & ~pwdata[2:0]) | irqEvt;
            end else begin
                irqStat_q <= irqStat_q | irqEvt;
            end
            if (wrEn && paddr == `OFS_IRQMASK) begin
                irqMask_q <= pwdata[2:0];
            end
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // ------------------------------------------------------------
    // apb read
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= '0;
            if (psel && !penable && !pwrite) begin
                if (paddr == `OFS_CTRL) begin
                    prdata <= {23'h0, laser_q, 2'h0, sens_q, filt_q};
                end else if (paddr == `OFS_OFFSET) begin
                    prdata <= offset_q;
                end else if (paddr == `OFS_TARGET) begin
                    prdata <= target_q;
                end else if (paddr == `OFS_WINMIN) begin
                    prdata <= winMin_q;
                end else if (paddr == `OFS_WINMAX) begin
                    prdata <= winMax_q;
                end else if (paddr == `OFS_STATUS) begin
                    prdata <= {29'h0, lastOk_q, laser_q, noSignal};
                end else if (paddr == `OFS_IRQSTAT) begin
                    prdata <= {29'h0, irqStat_q};
                end else if (paddr == `OFS_IRQMASK) begin
                    prdata <= {29'h0, irqMask_q};
                end else if (paddr == `OFS_RESULT) begin
                    prdata <= 32'(distOut);
                end
            end
        end
    end
    // rdEn kept for symmetry of decode
    logic unusedRd;
    assign unusedRd = rdEn;
endmodule

// *** rtl/dist_post_cfg.svh ***
`ifndef DIST_POST_CFG_SVH
`define DIST_POST_CFG_SVH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_OFFSET      8'h04
`define OFS_TARGET      8'h08
`define OFS_WINMIN      8'h0C
`define OFS_WINMAX      8'h10
`define OFS_APPLY       8'h14
`define OFS_STATUS      8'h18
`define OFS_IRQSTAT     8'h1C
`define OFS_IRQMASK     8'h20
`define OFS_RESULT      8'h24

// control field positions
`define CTRL_FILT_LSB   0
`define CTRL_FILT_MSB   3
`define CTRL_SENS_LSB   4
`define CTRL_SENS_MSB   5
`define CTRL_LASER_BIT  8

// reset values
`define FILT_RST        4'h3
`define SENS_RST        2'h0
`define LASER_RST       1'b1
`define OFFSET_RST      32'h0000_0000
`define TARGET_RST      32'h0000_0000

// working range bounds in micrometres
`define RANGE_LO        32'h0000_0000
`define RANGE_HI        32'h000F_4240

// filter setting limit
`define FILT_MAX        4'h9

// interrupt bits
`define IRQ_NEW         0
`define IRQ_NOSIG       1
`define IRQ_APPLIED     2

`endif

// *** rtl/dist_post_pkg.sv ***
package dist_post_pkg;
    typedef enum logic [1:0] {
        SENS_STANDARD,
        SENS_HIGH,
        SENS_MAXIMUM,
        SENS_RESERVED
    } sens_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCUM,
        ST_OUTPUT
    } pipe_t;
endpackage

// *** rtl/running_avg.sv ***
`timescale 1ns/100ps
// running average over the last 2**shift samples (fewer after a flush), shift chosen at run time, at most log2 of DEPTH
module running_avg #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 512
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             flush,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic [3:0]       shift,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0]    hist [DEPTH];
    logic [AW-1:0]       wrPtr_q;
    logic [WIDTH+AW-1:0] sum_q;
    logic [AW:0]         fill_q;
    logic [AW:0]         winLen;
    logic [AW-1:0]       oldIdx;
    logic [WIDTH-1:0]    oldVal;
    logic                full;

    assign winLen = (AW+1)'(1) << shift;
    assign full   = (fill_q >= winLen);
    assign oldIdx = wrPtr_q - winLen[AW-1:0];
    assign oldVal = full ? hist[oldIdx] : '0;

    always_ff @(posedge clk) begin
        if (ce && inValid) begin
            hist[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || (ce && flush)) begin
            wrPtr_q <= '0;
            fill_q  <= '0;
            sum_q   <= '0;
        end else if (ce && inValid) begin
            wrPtr_q <= wrPtr_q + 1'b1;
            if (!full) begin
                fill_q <= fill_q + 1'b1;
            end
            sum_q <= sum_q + (WIDTH+AW)'(inData) - (WIDTH+AW)'(oldVal);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            outValid <= 1'b0;
            outData  <= '0;
        end else if (ce) begin
            outValid <= inValid;
            if (inValid) begin
                outData <= WIDTH'((sum_q + (WIDTH+AW)'(inData) - (WIDTH+AW)'(oldVal))
                           / (full ? (WIDTH+AW)'(winLen) : (WIDTH+AW)'(fill_q + 1'b1)));
            end
        end
    end
endmodule
